/* uasp_pkg.sv */
package uasp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_TX_CONTROL    = 6'h05;
  localparam logic [5:0] IDX_IFACE_SELECT  = 6'h06;
  localparam logic [5:0] IDX_RX_STATUS     = 6'h07;
  localparam logic [5:0] IDX_RX_BUFFER     = 6'h08;
  localparam logic [5:0] IDX_TX_BUFFER     = 6'h09;
  localparam logic [5:0] IDX_IRQ_FLAGS     = 6'h0A;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TXC_NINTH    = 7;
  localparam int TXC_LEN_LO   = 5;
  localparam int TXC_RATE_LO  = 2;
  localparam int TXC_EMPTY    = 1;
  localparam int TXC_ENABLE   = 0;
  localparam int IFS_MODE_LO  = 4;
  localparam int IFS_INVERT   = 3;
  localparam int RXS_NINTH    = 7;
  localparam int RXS_EVEN     = 6;
  localparam int RXS_PAR_EN   = 5;
  localparam int RXS_PAR_ERR  = 4;
  localparam int RXS_OVERRUN  = 3;
  localparam int RXS_FRAMING  = 2;
  localparam int RXS_FULL     = 1;
  localparam int RXS_ENABLE   = 0;
  localparam int IRQ_RX_ERR   = 6;
  localparam int IRQ_RX_FULL  = 5;
  localparam int IRQ_TX_EMPTY = 4;

  // ----------------------------------------------------------------
  // Field codes, divisors and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_7BIT   = 2'h0;
  localparam logic [1:0] LEN_8BIT   = 2'h1;
  localparam logic [1:0] LEN_9BIT   = 2'h2;
  localparam logic [1:0] MODE_IO    = 2'h0;
  localparam logic [1:0] MODE_SPI   = 2'h1;
  localparam logic [1:0] MODE_UART  = 2'h2;
  localparam logic [2:0] RATE_TIMER = 3'h6;
  localparam logic [8:0] DIV_13     = 9'h00D;
  localparam logic [8:0] DIV_26     = 9'h01A;
  localparam logic [8:0] DIV_52     = 9'h034;
  localparam logic [8:0] DIV_104    = 9'h068;
  localparam logic [8:0] DIV_208    = 9'h0D0;
  localparam logic [8:0] DIV_416    = 9'h1A0;
  localparam logic [8:0] DIV_96     = 9'h060;
  localparam logic [8:0] DIV_TIMER  = 9'h001;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic       RST_TX_EMPTY = 1'b1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* uasp_serial_port.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - Nine-bit mode sends control bit 7 ninth.
// - Length code 00/01/10 gives 7/8/9 bits.
// - Rate code picks Fc divisor or timer four.
// - Transmit-empty flag high when holding buffer empty.
// - Writing transmit buffer clears transmit-empty flag.
// - Setting transmit enable clears transmit-empty flag.
// - Transmitter runs only while transmit enable set.
// - Mode field selects I/O, SPI or UART pins; only UART drives txd_oe and lets the receiver start.
// - Invert bit inverts both serial pins.
// - Ninth received bit lands in status bit 7.
// - Parity sense: 0 odd, 1 even.
// - Parity enable adds and checks parity bit.
// - Error flags stick until software clears.
// - Receive-full set when character complete.
// - Reading status clears receive-full flag.
// - Setting receive enable clears receive-full flag.
// - Receiver runs only while receive enable set.
// - Receive buffer is read only.
// - Transmit buffer is write only.
// - Full and empty events raise sticky flags.
// - Receive errors raise flag, cleared by disable.

module uasp_serial_port (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output wire logic        awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  // AXI4-Lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output wire logic        arready,
  // AXI4-Lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Bit-rate source from timer four, one-cycle pulse per bit
  input  wire logic        timer_four_output,
  // Serial pins
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe
);

  typedef enum logic {TX_IDLE, TX_SHIFT} uasp_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BUSY} uasp_rx_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                 tx_ninth_bit;
  logic [1:0]           char_length_field;
  logic [2:0]           bit_rate_field;
  logic                 tx_empty_flag;
  logic                 transmit_enable;
  logic [1:0]           interface_mode_field;
  logic                 pin_invert_enable;
  logic                 rx_ninth_bit;
  logic                 parity_even;
  logic                 parity_enable;
  logic                 parity_fault_flag;
  logic                 rx_lost_char_flag;
  logic                 framing_fault_flag;
  logic                 rx_full_flag;
  logic                 receive_enable;
  logic [7:0]           rx_data_buffer;
  logic [7:0]           tx_data_buffer;
  logic                 tx_pending;
  logic                 rx_error_irq_flag;
  logic                 rx_full_irq_flag;
  logic                 tx_empty_irq_flag;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic                 aw_have;
  logic                 w_have;
  logic [5:0]           aw_idx;
  logic [7:0]           w_byte;
  logic                 w_lane0;
  logic [7:0]           rd_mux;
  logic                 rd_hit;

  wire                  wr_go   = aw_have && w_have;
  wire                  wr_hit  = (aw_idx >= uasp_pkg::IDX_TX_CONTROL) &&
                                  (aw_idx <= uasp_pkg::IDX_IRQ_FLAGS);
  wire                  wr_en   = wr_go && w_lane0;
  wire                  wr_ctrl = wr_en && (aw_idx == uasp_pkg::IDX_TX_CONTROL);
  wire                  wr_ifs  = wr_en && (aw_idx == uasp_pkg::IDX_IFACE_SELECT);
  wire                  wr_stat = wr_en && (aw_idx == uasp_pkg::IDX_RX_STATUS);
  wire                  wr_txb  = wr_en && (aw_idx == uasp_pkg::IDX_TX_BUFFER);
  wire                  wr_irq  = wr_en && (aw_idx == uasp_pkg::IDX_IRQ_FLAGS);
  wire                  ar_fire = arvalid && arready;
  wire [5:0]            rd_idx  = araddr[7:2];
  wire                  rd_stat = ar_fire && (rd_idx == uasp_pkg::IDX_RX_STATUS);

  assign awready = !aw_have && !bvalid;
  assign wready  = !w_have && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_idx  <= 6'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= uasp_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_idx  <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        w_have  <= 1'b1;
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? uasp_pkg::RESP_OKAY : uasp_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // The transmit buffer reads as zero: it never returns its character.
  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      uasp_pkg::IDX_TX_CONTROL:
        rd_mux = {tx_ninth_bit, char_length_field, bit_rate_field,
                  tx_empty_flag, transmit_enable};
      uasp_pkg::IDX_IFACE_SELECT:
        rd_mux = {2'h0, interface_mode_field, pin_invert_enable, 3'h0};
      uasp_pkg::IDX_RX_STATUS:
        rd_mux = {rx_ninth_bit, parity_even, parity_enable, parity_fault_flag,
                  rx_lost_char_flag, framing_fault_flag, rx_full_flag,
                  receive_enable};
      uasp_pkg::IDX_RX_BUFFER:
        rd_mux = rx_data_buffer;
      uasp_pkg::IDX_TX_BUFFER:
        rd_mux = 8'h00;
      uasp_pkg::IDX_IRQ_FLAGS:
        rd_mux = {1'b0, rx_error_irq_flag, rx_full_irq_flag, tx_empty_irq_flag, 4'h0};
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= uasp_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_mux};
      rresp  <= rd_hit ? uasp_pkg::RESP_OKAY : uasp_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit-rate selection
  // ----------------------------------------------------------------
  logic [8:0]           period;

  always_comb begin
    case (bit_rate_field)
      3'h0:    period = uasp_pkg::DIV_13;
      3'h1:    period = uasp_pkg::DIV_26;
      3'h2:    period = uasp_pkg::DIV_52;
      3'h3:    period = uasp_pkg::DIV_104;
      3'h4:    period = uasp_pkg::DIV_208;
      3'h5:    period = uasp_pkg::DIV_416;
      3'h6:    period = uasp_pkg::DIV_TIMER;
      default: period = uasp_pkg::DIV_96;
    endcase
  end

  // In timer mode every timer pulse is one bit, so the count runs on it.
  wire os_tick = (bit_rate_field == uasp_pkg::RATE_TIMER) ? timer_four_output : 1'b1;
  wire [3:0] data_len = (char_length_field == uasp_pkg::LEN_7BIT) ? 4'h7 :
                        (char_length_field == uasp_pkg::LEN_9BIT) ? 4'h9 : 4'h8;
  wire [3:0] frame_bits = data_len + {3'h0, parity_enable} + 4'h2;
  wire uart_mode = (interface_mode_field == uasp_pkg::MODE_UART);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  uasp_tx_state_t       tx_state;
  logic [11:0]          tx_shreg;
  logic [11:0]          tx_frame;
  logic [8:0]           tx_cnt;
  logic [3:0]           tx_left;
  logic [8:0]           tx_word;

  wire tx_bit_tick = (tx_state == TX_SHIFT) && os_tick && (tx_cnt == 9'h000);
  // A write in the same cycle wins the buffer, so the load waits a cycle.
  wire tx_load = (tx_state == TX_IDLE) && tx_pending && transmit_enable && !wr_txb;
  wire txe_rise = wr_ctrl && w_byte[uasp_pkg::TXC_ENABLE] && !transmit_enable;
  wire tx_par = ^tx_word ^ !parity_even;

  always_comb begin
    tx_word = {tx_ninth_bit, tx_data_buffer};
    if (data_len == 4'h7)
      tx_word[8:7] = 2'h0;
    else if (data_len == 4'h8)
      tx_word[8] = 1'b0;
    tx_frame = 12'hFFF;
    tx_frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(data_len))
        tx_frame[i + 1] = tx_word[i];
    end
    if (parity_enable)
      tx_frame[data_len + 4'h1] = tx_par;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TX_IDLE;
      tx_shreg <= 12'hFFF;
      tx_cnt   <= 9'h000;
      tx_left  <= 4'h0;
    end else if (!transmit_enable) begin
      tx_state <= TX_IDLE;
      tx_shreg <= 12'hFFF;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state <= TX_SHIFT;
            tx_shreg <= tx_frame;
            tx_left  <= frame_bits;
            tx_cnt   <= period - 9'h001;
          end
        end
        TX_SHIFT: begin
          if (tx_bit_tick) begin
            tx_shreg <= {1'b1, tx_shreg[11:1]};
            tx_left  <= tx_left - 4'h1;
            tx_cnt   <= period - 9'h001;
            if (tx_left == 4'h1)
              tx_state <= TX_IDLE;
          end else if (os_tick) begin
            tx_cnt <= tx_cnt - 9'h001;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  uasp_rx_state_t       rx_state;
  logic                 rx_sync1;
  logic                 rx_sync2;
  logic                 rx_prev;
  logic [11:0]          rx_sh;
  logic [8:0]           rx_cnt;
  logic [3:0]           rx_left;
  logic [3:0]           rx_len;
  logic                 rx_pen;
  logic [8:0]           rx_d9;

  wire rx_pin = rx_sync2 ^ pin_invert_enable;
  wire rx_fall = rx_prev && !rx_pin;
  wire [3:0] rx_total = rx_len + {3'h0, rx_pen} + 4'h2;
  wire rx_sample = (rx_state == RX_BUSY) && os_tick && (rx_cnt == 9'h000);
  wire rx_first = rx_sample && (rx_left == rx_total);
  wire rx_done = rx_sample && (rx_left == 4'h1) && receive_enable;
  wire [11:0] rx_next = {rx_pin, rx_sh[11:1]};
  wire [11:0] rx_aligned = rx_next >> (4'hC - rx_total);
  wire rx_par_err = rx_pen && (rx_aligned[rx_len + 4'h1] != (^rx_d9 ^ !parity_even));
  wire rx_frm_err = !rx_pin;
  wire rx_ovr_err = rx_full_flag && !rd_stat;
  wire rxe_rise = wr_stat && w_byte[uasp_pkg::RXS_ENABLE] && !receive_enable;

  always_comb begin
    rx_d9 = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(rx_len))
        rx_d9[i] = rx_aligned[i + 1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync1 <= 1'b1;
      rx_sync2 <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      rx_sync1 <= rxd_in;
      rx_sync2 <= rx_sync1;
      rx_prev  <= rx_pin;
    end
  end

  // The count restarts at the start edge, so sampling lands mid-bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_sh    <= 12'h000;
      rx_cnt   <= 9'h000;
      rx_left  <= 4'h0;
      rx_len   <= 4'h8;
      rx_pen   <= 1'b0;
    end else if (!receive_enable) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (rx_fall && uart_mode) begin
            rx_state <= RX_BUSY;
            rx_sh    <= 12'h000;
            rx_cnt   <= {1'b0, period[8:1]};
            rx_len   <= data_len;
            rx_pen   <= parity_enable;
            rx_left  <= frame_bits;
          end
        end
        RX_BUSY: begin
          if (rx_sample) begin
            rx_sh   <= rx_next;
            rx_cnt  <= period - 9'h001;
            rx_left <= rx_left - 4'h1;
            // A high start sample was a glitch, not a character.
            if ((rx_first && rx_pin) || rx_left == 4'h1)
              rx_state <= RX_IDLE;
          end else if (os_tick) begin
            rx_cnt <= rx_cnt - 9'h001;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control, status and flags; a hardware set always beats a clear
  // ----------------------------------------------------------------
  wire next_tx_empty = tx_load | (tx_empty_flag & !(wr_txb | txe_rise));
  wire next_rx_full = rx_done | (rx_full_flag & !(rd_stat | rxe_rise));
  wire next_par_err = (rx_done & rx_par_err) |
                      (parity_fault_flag & !(wr_stat & !w_byte[uasp_pkg::RXS_PAR_ERR]));
  wire next_ovr_err = (rx_done & rx_ovr_err) |
                      (rx_lost_char_flag & !(wr_stat & !w_byte[uasp_pkg::RXS_OVERRUN]));
  wire next_frm_err = (rx_done & rx_frm_err) |
                      (framing_fault_flag & !(wr_stat & !w_byte[uasp_pkg::RXS_FRAMING]));
  wire any_err = rx_done & (rx_par_err | rx_ovr_err | rx_frm_err);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tx_ninth_bit, char_length_field, bit_rate_field} <= 6'h00;
      transmit_enable      <= 1'b0;
      tx_empty_flag        <= uasp_pkg::RST_TX_EMPTY;
      interface_mode_field <= uasp_pkg::MODE_IO;
      pin_invert_enable    <= 1'b0;
      {parity_even, parity_enable, receive_enable} <= 3'h0;
      {parity_fault_flag, rx_lost_char_flag, framing_fault_flag} <= 3'h0;
      rx_full_flag         <= 1'b0;
      rx_ninth_bit         <= 1'b0;
      rx_data_buffer       <= uasp_pkg::RST_BYTE;
      tx_data_buffer       <= uasp_pkg::RST_BYTE;
      tx_pending           <= 1'b0;
      {rx_error_irq_flag, rx_full_irq_flag, tx_empty_irq_flag} <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        tx_ninth_bit      <= w_byte[uasp_pkg::TXC_NINTH];
        char_length_field <= w_byte[uasp_pkg::TXC_LEN_LO +: 2];
        bit_rate_field    <= w_byte[uasp_pkg::TXC_RATE_LO +: 3];
        transmit_enable   <= w_byte[uasp_pkg::TXC_ENABLE];
      end
      if (wr_ifs) begin
        interface_mode_field <= w_byte[uasp_pkg::IFS_MODE_LO +: 2];
        pin_invert_enable    <= w_byte[uasp_pkg::IFS_INVERT];
      end
      if (wr_stat) begin
        parity_even    <= w_byte[uasp_pkg::RXS_EVEN];
        parity_enable  <= w_byte[uasp_pkg::RXS_PAR_EN];
        receive_enable <= w_byte[uasp_pkg::RXS_ENABLE];
      end
      if (wr_txb) begin
        tx_data_buffer <= w_byte;
        tx_pending     <= 1'b1;
      end else if (tx_load) begin
        tx_pending <= 1'b0;
      end
      if (rx_done) begin
        rx_data_buffer <= rx_d9[7:0];
        rx_ninth_bit   <= rx_d9[8];
      end
      tx_empty_flag      <= next_tx_empty;
      rx_full_flag       <= next_rx_full;
      parity_fault_flag  <= next_par_err;
      rx_lost_char_flag  <= next_ovr_err;
      framing_fault_flag <= next_frm_err;
      rx_full_irq_flag   <= rx_done | (rx_full_irq_flag &
                            !(wr_irq & !w_byte[uasp_pkg::IRQ_RX_FULL]));
      tx_empty_irq_flag  <= tx_load | (tx_empty_irq_flag &
                            !(wr_irq & !w_byte[uasp_pkg::IRQ_TX_EMPTY]));
      rx_error_irq_flag  <= any_err | (rx_error_irq_flag & receive_enable &
                            !(wr_irq & !w_byte[uasp_pkg::IRQ_RX_ERR]));
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_out <= 1'b1;
      txd_oe  <= 1'b0;
    end else begin
      txd_out <= tx_shreg[0] ^ pin_invert_enable;
      txd_oe  <= uart_mode;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  tx_empty_write_a: assert property (
    wr_txb && !tx_load |=> !tx_empty_flag)
    else $error("transmit-empty flag not cleared by buffer write");
  tx_empty_enable_a: assert property (
    txe_rise |=> !tx_empty_flag ##1 (!tx_empty_flag || $past(tx_load)))
    else $error("transmit-empty flag not cleared by enable");
  tx_disable_idle_a: assert property (
    !transmit_enable |=> tx_state == TX_IDLE && tx_shreg[0])
    else $error("transmitter active while disabled");
  tx_start_bit_a: assert property (
    tx_load |=> !tx_shreg[0] && tx_left == frame_bits)
    else $error("frame does not open with a low start bit");
  pin_invert_a: assert property (
    tx_state == TX_IDLE && $stable(pin_invert_enable) && transmit_enable
    |=> txd_out == !pin_invert_enable)
    else $error("idle line level wrong for inversion setting");
  rx_full_set_a: assert property (
    rx_done |=> rx_full_flag && rx_full_irq_flag)
    else $error("receive-full not set after character");
  rx_full_read_a: assert property (
    rd_stat && !rx_done |=> !rx_full_flag)
    else $error("status read did not clear receive-full");
  rx_disable_idle_a: assert property (
    !receive_enable |=> rx_state == RX_IDLE)
    else $error("receiver active while disabled");
  framing_err_a: assert property (
    rx_done && rx_frm_err |=> framing_fault_flag && rx_error_irq_flag)
    else $error("low stop bit not flagged");
  overrun_err_a: assert property (
    rx_done && rx_ovr_err |=> rx_lost_char_flag ##1 (rx_lost_char_flag || $past(wr_stat)))
    else $error("overrun not flagged or not sticky");

  tx_frame_c:  cover property (tx_load ##[1:1000] tx_state == TX_IDLE);
  rx_char_c:   cover property (rx_done && !any_err);
  rx_parity_c: cover property (rx_done && rx_par_err);
  rx_ovr_c:    cover property (rx_done && rx_ovr_err);

endmodule

/* uasp_remote.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Remote transceiver on the serial pins
// ----------------------------------------------------------------
module uasp_remote #(
  parameter int BIT = 13
) (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  task automatic put(input logic b);
    @(posedge aclk);
    rxd <= b;
    repeat (BIT - 1) @(posedge aclk);
  endtask
  // Line returns to its idle high level after the stop bit.
  task automatic send(input logic [8:0] d, input int nb, input logic pe, input logic pb,
                      input logic sb);
    int i;
    put(1'b0);
    for (i = 0; i < nb; i++) put(d[i]);
    if (pe) put(pb);
    put(sb);
    @(posedge aclk);
    rxd <= 1'b1;
  endtask
  // Sampled on the falling clock edge so the registered pin has settled.
  task automatic listen(input int nb, output logic [8:0] v, output logic ok);
    int n;
    int i;
    v = 9'h000;
    for (n = 0; n < 3000 && txd; n++) @(negedge aclk);
    repeat (BIT / 2) @(negedge aclk);
    ok = !txd;
    for (i = 0; i < nb; i++) begin
      repeat (BIT) @(negedge aclk);
      v[i] = txd;
    end
    repeat (BIT) @(negedge aclk);
    ok = ok & txd;
  endtask
endmodule

/* uasp_serial_port_test.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module uasp_serial_port_test;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ok;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, wresp;
  logic        awready, wready, bvalid, arready, rvalid, txd_out, txd_oe, rxd;
  logic [8:0]  v;
  int          fails = 0, cmp_count = 0;
  always #10 aclk = ~aclk;
  uasp_serial_port i_uasp_serial_port (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .timer_four_output(1'b0),
    .rxd_in(rxd), .txd_out(txd_out), .txd_oe(txd_oe));
  uasp_remote #(.BIT(13)) i_uasp_remote (.aclk(aclk), .txd(txd_out), .rxd(rxd));
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tmo;
    fails++;
    $display("Error %0t: bus wait ran out", $time);
    report_and_stop();
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w, b;
    int n;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      a = awready;
      w = wready;
      b = bvalid;
      if (b) wresp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (n == 100) tmo();
  endtask
  task automatic rdc(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
    logic a, rv;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      a = arready & arvalid;
      rv = rvalid;
      q = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (rv) break;
    end
    rready <= 1'b0;
    if (n == 100) tmo();
    chk({r, q}, {er, 24'h0, e});
  endtask
  task t_reset;
    rdc(6'h05, 8'h02, 2'h0);
    rdc(6'h3F, 8'h00, 2'h2);
    wr(6'h3F, 8'h00);
    chk(wresp, 2'h2);
    wr(6'h08, 8'h5A);
    chk(wresp, 2'h0);
    rdc(6'h08, 8'h00, 2'h0);
    wr(6'h09, 8'h5A);
    rdc(6'h09, 8'h00, 2'h0);
    chk(txd_out, 1'b1);
    $display("t_reset done");
  endtask
  task t_tx;
    wr(6'h06, 8'h20);
    @(negedge aclk);
    chk(txd_oe, 1'b1);
    // The byte parked in the buffer by the reset test leaves once the enable lands.
    fork
      wr(6'h05, 8'h21);
      i_uasp_remote.listen(8, v, ok);
    join
    chk({ok, v}, {1'b1, 9'h05A});
    fork
      wr(6'h09, 8'hA5);
      i_uasp_remote.listen(8, v, ok);
    join
    chk({ok, v}, {1'b1, 9'h0A5});
    rdc(6'h05, 8'h23, 2'h0);
    rdc(6'h0A, 8'h10, 2'h0);
    $display("t_tx done");
  endtask
  task t_rx;
    wr(6'h07, 8'h61);
    i_uasp_remote.send(9'h03C, 8, 1'b1, 1'b0, 1'b1);
    rdc(6'h07, 8'h63, 2'h0);
    rdc(6'h08, 8'h3C, 2'h0);
    rdc(6'h07, 8'h61, 2'h0);
    $display("t_rx done");
  endtask
  // Second character lands while full is still set, with bad parity and a low stop.
  task t_err;
    i_uasp_remote.send(9'h03C, 8, 1'b1, 1'b0, 1'b1);
    i_uasp_remote.send(9'h0C3, 8, 1'b1, 1'b1, 1'b0);
    rdc(6'h07, 8'h7F, 2'h0);
    rdc(6'h07, 8'h7D, 2'h0);
    $display("t_err done");
  endtask
  // Nine-bit characters both ways, parity off; the status write also clears old errors.
  task t_nine;
    wr(6'h07, 8'h01);
    wr(6'h05, 8'hC1);
    fork
      wr(6'h09, 8'h5A);
      i_uasp_remote.listen(9, v, ok);
    join
    chk({ok, v}, {1'b1, 9'h15A});
    i_uasp_remote.send(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
    rdc(6'h07, 8'h83, 2'h0);
    rdc(6'h08, 8'hA5, 2'h0);
    $display("t_nine done");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_nine();
    report_and_stop();
  end
endmodule
